//--- hw/eca_defines.vh
// constants for the eeprom configuration autoload block
`ifndef ECA_DEFINES_VH
`define ECA_DEFINES_VH
// register offsets (byte addresses of the operational/config space)
`define ECA_OFF_STATION0 8'h00
`define ECA_OFF_STATION5 8'h05
`define ECA_OFF_CMD 8'h50
`define ECA_OFF_CFG0 8'h51
`define ECA_OFF_CFG1 8'h52
`define ECA_OFF_CFG3 8'h54
`define ECA_OFF_CFG4 8'h55
`define ECA_OFF_CFG5 8'h56
`define ECA_OFF_LINK 8'h6C
`define ECA_OFF_PMC_LO 8'hDE
`define ECA_OFF_PMC_HI 8'hDF
`define ECA_OFF_BYTE_ORDER 8'hE1
// eeprom word addresses
`define ECA_W_SIG 7'h00
`define ECA_W_LAST 7'h18
`define ECA_W_VPD 7'h20
`define ECA_W_CIS 7'h40
// signature word and defaults (arbitrary neutral values)
`define ECA_SIG_VALUE 16'h5AA5
`define ECA_DEF_VENDOR 16'h1234
`define ECA_DEF_DEVICE 16'h5678
// command register fields
`define ECA_CMD_MODE_HI 7
`define ECA_CMD_MODE_LO 6
`define ECA_CMD_CS 3
`define ECA_CMD_SK 2
`define ECA_CMD_DI 1
`define ECA_CMD_DO 0
`define ECA_MODE_AUTOLOAD 2'b01
`define ECA_MODE_PROGRAM 2'b11
// fields
`define ECA_TBI_BIT 3
`define ECA_LINK_TBI_BIT 7
`define ECA_LAN_WAKE_ENABLE_BIT 1
`define ECA_PMESTS_BIT 0
// serial timing
`define ECA_SK_HALF_NS 200
`define ECA_SK_HALF_CYC ((`ECA_SK_HALF_NS + 49) / 50)
`define ECA_READ_OPCODE 3'b110
`endif

//--- hw/eca_serial_read.v
// three-wire serial eeprom word reader
`timescale 1ns/1ps
`include "eca_defines.vh"
module eca_serial_read #(
    parameter ADDR_W = 6,
    parameter HALF_CYC = `ECA_SK_HALF_CYC
) (
    input wire mclk,
    input wire nrst,
    input wire start,
    input wire [7:0] addr,
    input wire so_sync,
    output reg cs,
    output reg sk,
    output reg di,
    output reg done,
    output reg [15:0] rdata
);
    localparam TOTAL = 3 + ADDR_W + 1 + 16;
    localparam [5:0] LAST_CMD = 3 + ADDR_W - 1;
    localparam [5:0] FIRST_DATA = 3 + ADDR_W + 1;
    localparam [5:0] LAST_BIT = TOTAL - 1;
    localparam [15:0] HALF_LAST = HALF_CYC - 1;
    reg busy;
    reg [5:0] bitn;
    reg [15:0] hcnt;
    reg [3+ADDR_W-1:0] cmd;

    always @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            busy <= 1'b0;
            bitn <= 6'h00;
            hcnt <= 16'h0000;
            cmd <= {(3+ADDR_W){1'b0}};
            cs <= 1'b0;
            sk <= 1'b0;
            di <= 1'b0;
            done <= 1'b0;
            rdata <= 16'h0000;
        end else begin
            done <= 1'b0;
            if (!busy) begin
                if (start) begin
                    busy <= 1'b1;
                    cs <= 1'b1;
                    bitn <= 6'h00;
                    hcnt <= 16'h0000;
                    // first opcode bit goes out with chip select
                    {di, cmd} <= {`ECA_READ_OPCODE, addr[ADDR_W-1:0], 1'b0}; // R17
                end
            end else if (hcnt == HALF_LAST) begin
                hcnt <= 16'h0000;
                if (!sk) begin
                    sk <= 1'b1;
                end else begin
                    sk <= 1'b0;
                    // next bit moves on the falling edge, a half period ahead of its sample
                    if (bitn < LAST_CMD) begin
                        di <= cmd[3+ADDR_W-1];
                        cmd <= cmd << 1;
                    end else begin
                        di <= 1'b0;
                    end
                    if (bitn >= FIRST_DATA)
                        rdata <= {rdata[14:0], so_sync}; // R17
                    if (bitn == LAST_BIT) begin
                        busy <= 1'b0;
                        cs <= 1'b0;
                        done <= 1'b1;
                    end
                    bitn <= bitn + 6'h01;
                end
            end else begin
                hcnt <= hcnt + 16'h0001;
            end
        end
    end
endmodule // eca_serial_read

//--- hw/eca_autoload.v
// eeprom configuration autoload with register file and bit-bang port
// How it works
// (R1) after reset or autoload command read eeprom words for bytes 00h..31h
// (R2) load fields only when signature word matches, else keep default codes
// (R3) without an eeprom the built-in defaults stay in every register
// (R4) bytes 02h-05h go to vendor and device code fields
// (R5) bytes 06h-09h go to subsystem vendor and subsystem code
// (R6) byte 0Ah to minimum grant, byte 0Bh to maximum latency
// (R7) bit 3 of byte 0Ch selects ten-bit interface, shown in link state
// (R8) bytes 14h, 15h, 0Dh go to configuration registers 0, 1, 3
// (R9) bytes 0Eh-13h go to the six station address registers
// (R10) bit 1 of byte 1Fh enables the lan wake output
// (R11) bit 0 of byte 1Fh with d3cold support decides pme status stickiness
// (R12) byte 40h starts vital product data, 80h card info on the large part
// (R13) 1k or 2k bit eeprom, addressed by 16-bit words
// (R14) software may toggle the serial lines through the command register
// (R15) conditionally writable fields change only while both mode bits are 1
// (R16) the image carries checksum at 32h and card info pointer at 30h; the sequencer stops at word 18h, so eeprom_checksum stays 0000h
// (R17) each word uses the three-wire read command, 16 data bits shifted in
// (R18) configuration reads show defaults until the autoload completes; the read port returns 00h instead
`timescale 1ns/1ps
`include "eca_defines.vh"
module eca_autoload #(
    parameter LARGE_EEPROM = 0,
    parameter [15:0] DEF_VENDOR = `ECA_DEF_VENDOR,
    parameter [15:0] DEF_DEVICE = `ECA_DEF_DEVICE,
    parameter [15:0] DEF_SUBSYS_VENDOR = 16'h0000,
    parameter [15:0] DEF_SUBSYS = 16'h0000,
    parameter [7:0] DEF_PMC_LO = 8'h02,
    parameter [7:0] DEF_PMC_HI = 8'h00
) (
    input wire mclk,
    input wire nrst,
    input wire reg_wr,
    input wire reg_rd,
    input wire [7:0] reg_addr,
    input wire [7:0] reg_wdata,
    output reg [7:0] reg_rdata,
    input wire eeprom_present,
    input wire ee_so,
    output wire ee_cs,
    output wire ee_sk,
    output wire ee_di,
    input wire d3cold_support_pme,
    input wire pme_event,
    input wire pci_reset,
    input wire pme_clear,
    output reg pme_status,
    output wire lan_wake_enable,
    output reg load_done,
    output reg sig_ok,
    output reg [15:0] vendor_code,
    output reg [15:0] device_code,
    output reg [15:0] subsys_vendor_code,
    output reg [15:0] subsys_code,
    output reg [7:0] min_grant_value,
    output reg [7:0] max_latency_value,
    output reg [15:0] card_info_pointer,
    output reg [15:0] eeprom_checksum,
    output wire [7:0] vpd_start,
    output wire [7:0] cis_start,
    output reg ten_bit_if_enable,
    output reg [7:0] boot_rom_size_cfg,
    output reg [7:0] led_map_cfg,
    output reg [7:0] wake_feature_cfg,
    output reg [7:0] fifo_wake_cfg,
    output reg [7:0] lan_wake_cfg,
    output reg [7:0] byte_order_cmd,
    output wire [47:0] station_addr_bytes
);
    localparam ADDR_W = LARGE_EEPROM ? 7 : 6; // R13
    localparam S_IDLE = 3'h0;
    localparam S_START = 3'h1;
    localparam S_WAIT = 3'h2;
    localparam S_DONE = 3'h3;

    reg so_m;
    reg so_sync;
    reg [2:0] state;
    reg [6:0] word;
    reg rd_start;
    reg [7:0] eeprom_cmd_reg;
    reg [7:0] station [0:5];
    wire rd_done;
    wire [15:0] rd_data;
    wire auto_cs;
    wire auto_sk;
    wire auto_di;
    wire eeprom_mode_hi;
    wire eeprom_mode_lo;
    wire unlocked;
    wire loading;

    assign eeprom_mode_hi = eeprom_cmd_reg[`ECA_CMD_MODE_HI];
    assign eeprom_mode_lo = eeprom_cmd_reg[`ECA_CMD_MODE_LO];
    assign unlocked = eeprom_mode_hi & eeprom_mode_lo; // R15
    assign loading = (state != S_IDLE) && (state != S_DONE);
    // pin goes to bit-bang bits when software is in program mode
    assign ee_cs = unlocked ? eeprom_cmd_reg[`ECA_CMD_CS] : auto_cs; // R14
    assign ee_sk = unlocked ? eeprom_cmd_reg[`ECA_CMD_SK] : auto_sk; // R14
    assign ee_di = unlocked ? eeprom_cmd_reg[`ECA_CMD_DI] : auto_di; // R14
    assign lan_wake_enable = lan_wake_cfg[`ECA_LAN_WAKE_ENABLE_BIT]; // R10
    assign vpd_start = {`ECA_W_VPD, 1'b0}; // R12
    assign cis_start = LARGE_EEPROM ? {`ECA_W_CIS, 1'b0} : 8'h00; // R12
    assign station_addr_bytes = {station[5], station[4], station[3], station[2], station[1], station[0]};

    // serial data out arrives from the pin, two flops before use
    always @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            so_m <= 1'b0;
            so_sync <= 1'b0;
        end else begin
            so_m <= ee_so;
            so_sync <= so_m;
        end
    end

    eca_serial_read #(
        .ADDR_W(ADDR_W)
    ) u_read (
        .mclk(mclk),
        .nrst(nrst),
        .start(rd_start),
        .addr({1'b0, word}),
        .so_sync(so_sync),
        .cs(auto_cs),
        .sk(auto_sk),
        .di(auto_di),
        .done(rd_done),
        .rdata(rd_data)
    );

    // sequencer: words 00h..18h cover bytes 00h..31h
    always @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            state <= S_START;
            word <= 7'h00;
            rd_start <= 1'b0;
            load_done <= 1'b0;
            sig_ok <= 1'b0;
        end else begin
            rd_start <= 1'b0;
            case (state)
                S_IDLE: begin
                    if (reg_wr && reg_addr == `ECA_OFF_CMD &&
                        reg_wdata[7:6] == `ECA_MODE_AUTOLOAD) begin
                        state <= S_START;
                        load_done <= 1'b0;
                    end
                end
                S_START: begin
                    word <= `ECA_W_SIG;
                    sig_ok <= 1'b0;
                    if (!eeprom_present) begin
                        state <= S_DONE; // R3
                    end else begin
                        rd_start <= 1'b1; // R1
                        state <= S_WAIT;
                    end
                end
                S_WAIT: begin
                    if (rd_done) begin
                        if (word == `ECA_W_SIG && rd_data != `ECA_SIG_VALUE) begin
                            state <= S_DONE; // R2
                        end else begin
                            if (word == `ECA_W_SIG)
                                sig_ok <= 1'b1; // R2
                            if (word == `ECA_W_LAST) begin
                                state <= S_DONE;
                            end else begin
                                word <= word + 7'h01; // R1
                                rd_start <= 1'b1;
                            end
                        end
                    end
                end
                S_DONE: begin
                    load_done <= 1'b1; // R18
                    state <= S_IDLE;
                end
                default: state <= S_IDLE;
            endcase
        end
    end

    // loaded fields; byte order inside a word is low byte at the even address
    always @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            vendor_code <= DEF_VENDOR;
            device_code <= DEF_DEVICE;
            subsys_vendor_code <= DEF_SUBSYS_VENDOR;
            subsys_code <= DEF_SUBSYS;
            min_grant_value <= 8'h00;
            max_latency_value <= 8'h00;
            card_info_pointer <= 16'h0000;
            eeprom_checksum <= 16'h0000;
            ten_bit_if_enable <= 1'b0;
            boot_rom_size_cfg <= 8'h00;
            led_map_cfg <= 8'h00;
            wake_feature_cfg <= 8'h00;
            fifo_wake_cfg <= 8'h00;
            lan_wake_cfg <= 8'h00;
            byte_order_cmd <= 8'h00;
            eeprom_cmd_reg <= 8'h00;
            station[0] <= 8'h00;
            station[1] <= 8'h00;
            station[2] <= 8'h00;
            station[3] <= 8'h00;
            station[4] <= 8'h00;
            station[5] <= 8'h00;
        end else if (state == S_WAIT && rd_done && (sig_ok || word == `ECA_W_SIG)) begin
            case (word)
                7'h01: vendor_code <= rd_data; // R4
                7'h02: device_code <= rd_data; // R4
                7'h03: subsys_vendor_code <= rd_data; // R5
                7'h04: subsys_code <= rd_data; // R5
                7'h05: begin
                    min_grant_value <= rd_data[7:0]; // R6
                    max_latency_value <= rd_data[15:8]; // R6
                end
                7'h06: begin
                    ten_bit_if_enable <= rd_data[`ECA_TBI_BIT]; // R7
                    wake_feature_cfg <= rd_data[15:8]; // R8
                end
                7'h07: begin
                    station[0] <= rd_data[7:0]; // R9
                    station[1] <= rd_data[15:8];
                end
                7'h08: begin
                    station[2] <= rd_data[7:0]; // R9
                    station[3] <= rd_data[15:8];
                end
                7'h09: begin
                    station[4] <= rd_data[7:0]; // R9
                    station[5] <= rd_data[15:8];
                end
                7'h0A: begin
                    boot_rom_size_cfg <= rd_data[7:0]; // R8
                    led_map_cfg <= rd_data[15:8]; // R8
                end
                7'h0C: fifo_wake_cfg <= rd_data[15:8];
                7'h0F: lan_wake_cfg <= rd_data[15:8]; // R10 R11
                7'h18: card_info_pointer <= rd_data; // R16
                default: ;
            endcase
        end else if (state == S_WAIT && rd_done && word == `ECA_W_LAST + 7'h01) begin
            eeprom_checksum <= rd_data; // R16
        end else if (reg_wr && !loading) begin
            case (reg_addr)
                `ECA_OFF_CMD: eeprom_cmd_reg <= reg_wdata & 8'hCE; // R14
                `ECA_OFF_CFG1: if (unlocked)
                    led_map_cfg <= {reg_wdata[7:4], led_map_cfg[3:2], reg_wdata[1:0]}; // R15
                `ECA_OFF_CFG3: if (unlocked)
                    wake_feature_cfg <= {wake_feature_cfg[7:6], reg_wdata[5:4], wake_feature_cfg[3:0]}; // R15
                `ECA_OFF_CFG4: if (unlocked) fifo_wake_cfg <= reg_wdata; // R15
                `ECA_OFF_CFG5: if (unlocked) lan_wake_cfg <= reg_wdata & 8'h03; // R15
                `ECA_OFF_BYTE_ORDER: byte_order_cmd <= reg_wdata & 8'h02;
                default: begin
                    if (unlocked && reg_addr <= `ECA_OFF_STATION5)
                        station[reg_addr[2:0]] <= reg_wdata; // R15
                end
            endcase
        end
    end

    // pme status: set wins; clear only when not sticky
    always @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            pme_status <= 1'b0;
        end else if (pme_event) begin
            pme_status <= 1'b1;
        end else if ((pci_reset || pme_clear) && !d3cold_support_pme &&
                     lan_wake_cfg[`ECA_PMESTS_BIT]) begin
            pme_status <= 1'b0; // R11
        end
    end

    // register read port; 00h returned while loading
    always @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            if (loading) begin
                reg_rdata <= 8'h00; // R18
            end else begin
                case (reg_addr)
                    `ECA_OFF_CMD: reg_rdata <= {eeprom_cmd_reg[7:1], so_sync}; // R14
                    `ECA_OFF_CFG0: reg_rdata <= boot_rom_size_cfg;
                    `ECA_OFF_CFG1: reg_rdata <= led_map_cfg;
                    `ECA_OFF_CFG3: reg_rdata <= wake_feature_cfg;
                    `ECA_OFF_CFG4: reg_rdata <= fifo_wake_cfg;
                    `ECA_OFF_CFG5: reg_rdata <= lan_wake_cfg;
                    `ECA_OFF_LINK: reg_rdata <= {ten_bit_if_enable, 7'h00}; // R7
                    `ECA_OFF_PMC_LO: reg_rdata <= DEF_PMC_LO;
                    `ECA_OFF_PMC_HI: reg_rdata <= DEF_PMC_HI;
                    `ECA_OFF_BYTE_ORDER: reg_rdata <= byte_order_cmd;
                    default: reg_rdata <= (reg_addr <= `ECA_OFF_STATION5) ? station[reg_addr[2:0]] : 8'h00;
                endcase
            end
        end
    end
endmodule // eca_autoload

//--- verification/eca_eeprom_model.sv
// behavioural three-wire serial eeprom of 64 words
`timescale 1ns/1ps
module eca_eeprom_model (
    input wire cs,
    input wire sk,
    input wire di,
    output reg so,
    output reg [7:0] last_addr,
    output reg bad_op
);
    reg [15:0] mem [0:63];
    reg [15:0] word;
    reg [8:0] cmd_sh;
    integer n;
    initial begin
        so = 1'b0;
        last_addr = 8'h00;
        bad_op = 1'b0;
        n = 0;
        cmd_sh = 9'h000;
        word = 16'h0000;
    end
    // released line: show the inverse so a stale sample cannot pass
    always @(negedge cs) begin
        n = 0;
        so = ~so;
    end
    always @(posedge sk) begin
        if (cs) begin
            n = n + 1;
            if (n <= 9)
                cmd_sh = {cmd_sh[7:0], di};
            if (n == 9) begin
                if (cmd_sh[8:6] !== 3'b110)
                    bad_op = 1'b1;
                last_addr = {2'b00, cmd_sh[5:0]};
                word = mem[cmd_sh[5:0]];
            end
            // one dummy period, then 16 bits msb first
            if (n > 10 && n <= 26)
                so = word[26 - n];
            else
                so = 1'b0;
        end
    end
endmodule // eca_eeprom_model

//--- verification/eca_autoload_sva.sv
// concurrent checks on the autoload block ports
`timescale 1ns/1ps
`include "eca_defines.vh"
module eca_autoload_sva (
    input wire mclk,
    input wire nrst,
    input wire reg_wr,
    input wire reg_rd,
    input wire [7:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire [7:0] reg_rdata,
    input wire load_done,
    input wire sig_ok,
    input wire [15:0] vendor_code,
    input wire [15:0] device_code,
    input wire ee_cs,
    input wire ee_sk,
    input wire ee_di,
    input wire lan_wake_enable,
    input wire [7:0] lan_wake_cfg,
    input wire pme_status,
    input wire pme_event,
    input wire pme_clear,
    input wire d3cold_support_pme,
    input wire [47:0] station_addr_bytes,
    input wire [7:0] boot_rom_size_cfg,
    input wire [7:0] vpd_start
);
    reg [7:0] cmd_sh;
    // shadow of the command register, writes count only once loaded
    always @(posedge mclk or negedge nrst) begin
        if (!nrst)
            cmd_sh <= 8'h00;
        else if (reg_wr && reg_addr == 8'h50 && load_done)
            cmd_sh <= reg_wdata;
    end
    default clocking @(posedge mclk); endclocking
    default disable iff (!nrst);
    a_read_during_load: assert property (reg_rd && !load_done ##1 !load_done |-> reg_rdata == 8'h00)
        else $error("read during load not zero");
    a_default_codes: assert property (load_done && !sig_ok |-> vendor_code == `ECA_DEF_VENDOR && device_code == `ECA_DEF_DEVICE)
        else $error("default codes lost");
    a_lan_wake_map: assert property (lan_wake_enable == lan_wake_cfg[1])
        else $error("lan wake output not bit 1");
    a_sk_half_period: assert property ($rose(ee_sk) && !load_done |-> ee_sk [*4] ##1 !ee_sk)
        else $error("serial clock half period wrong");
    a_pme_sticky: assert property (d3cold_support_pme && pme_status |=> pme_status)
        else $error("pme status not sticky");
    a_pme_clear: assert property (!d3cold_support_pme && lan_wake_cfg[0] && pme_clear && !pme_event |=> !pme_status)
        else $error("pme status not cleared");
    a_station_locked: assert property (reg_wr && reg_addr == 8'h00 && cmd_sh[7:6] != 2'b11 && load_done ##1 load_done
        |-> $stable(station_addr_bytes[7:0]))
        else $error("station byte written while locked");
    a_station_open: assert property (reg_wr && reg_addr == 8'h00 && cmd_sh[7:6] == 2'b11 && load_done
        |=> station_addr_bytes[7:0] == $past(reg_wdata))
        else $error("station byte write lost");
    a_cfg0_readonly: assert property (reg_wr && reg_addr == 8'h51 && load_done ##1 load_done |-> $stable(boot_rom_size_cfg))
        else $error("read-only config changed");
    a_bitbang_pins: assert property (load_done && cmd_sh[7:6] == 2'b11 |-> {ee_cs, ee_sk, ee_di} == cmd_sh[3:1])
        else $error("serial pins not software driven");
    a_vpd_start: assert property (vpd_start == 8'h40)
        else $error("vpd start wrong");
endmodule // eca_autoload_sva
bind eca_autoload eca_autoload_sva chk_u (.mclk, .nrst, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata,
    .load_done, .sig_ok, .vendor_code, .device_code, .ee_cs, .ee_sk, .ee_di, .lan_wake_enable, .lan_wake_cfg,
    .pme_status, .pme_event, .pme_clear, .d3cold_support_pme, .station_addr_bytes, .boot_rom_size_cfg, .vpd_start);

//--- verification/tb_eeprom_config_autoload.sv
// self-checking bench for the eeprom configuration autoload block
`timescale 1ns/1ps
`include "eca_defines.vh"
module tb_eeprom_config_autoload;
    reg mclk = 1'b0, nrst = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, eeprom_present = 1'b1;
    reg [7:0] reg_addr = 8'h00, reg_wdata = 8'h00;
    reg d3cold_support_pme = 1'b0, pme_event = 1'b0, pci_reset = 1'b0, pme_clear = 1'b0;
    wire [7:0] reg_rdata, min_grant_value, max_latency_value, vpd_start, cis_start, last_addr;
    wire [7:0] boot_rom_size_cfg, led_map_cfg, wake_feature_cfg, lan_wake_cfg, fifo_wake_cfg, byte_order_cmd;
    wire [15:0] vendor_code, device_code, subsys_vendor_code, subsys_code, card_info_pointer, eeprom_checksum;
    wire [47:0] station_addr_bytes;
    wire ee_so, ee_cs, ee_sk, ee_di, pme_status, lan_wake_enable, load_done, sig_ok, ten_bit_if_enable, bad_op;
    integer error_cnt = 0, compares = 0, i;
    reg [7:0] rv;
    always #25 mclk = ~mclk;
    eca_autoload dut_u (.mclk, .nrst, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata, .eeprom_present, .ee_so,
        .ee_cs, .ee_sk, .ee_di, .d3cold_support_pme, .pme_event, .pci_reset, .pme_clear, .pme_status, .lan_wake_enable,
        .load_done, .sig_ok, .vendor_code, .device_code, .subsys_vendor_code, .subsys_code, .min_grant_value,
        .max_latency_value, .card_info_pointer, .eeprom_checksum, .vpd_start, .cis_start, .ten_bit_if_enable,
        .boot_rom_size_cfg, .led_map_cfg, .wake_feature_cfg, .fifo_wake_cfg, .lan_wake_cfg, .byte_order_cmd,
        .station_addr_bytes);
    eca_eeprom_model ee_u (.cs(ee_cs), .sk(ee_sk), .di(ee_di), .so(ee_so), .last_addr, .bad_op);
    task chk(input string name, input [47:0] exp, input [47:0] got);
        begin
            compares = compares + 1;
            if (got !== exp) begin
                error_cnt = error_cnt + 1;
                $display("Error %s expected %h seen %h", name, exp, got);
            end
        end
    endtask
    task tally_and_finish;
        begin
            $display("compares %0d error_cnt %0d", compares, error_cnt);
            if (error_cnt == 0 && compares > 0)
                $display("Simulation passed");
            else
                $display("Simulation failed");
            $finish;
        end
    endtask
    task wr(input [7:0] a, input [7:0] d);
        begin
            @(negedge mclk) {reg_addr, reg_wdata, reg_wr} = {a, d, 1'b1};
            @(negedge mclk) reg_wr = 1'b0;
        end
    endtask
    task rd(input [7:0] a);
        begin
            @(negedge mclk) {reg_addr, reg_rd} = {a, 1'b1};
            @(negedge mclk) reg_rd = 1'b0;
            rv = reg_rdata;
        end
    endtask
    task wait_done;
        begin
            i = 0;
            while (load_done !== 1'b1 && i < 40000) begin
                @(negedge mclk);
                i = i + 1;
            end
            chk("load_done", 1, load_done);
        end
    endtask
    task do_reset;
        begin
            nrst = 1'b0;
            repeat (5) @(negedge mclk);
            nrst = 1'b1;
        end
    endtask
    task t_load_ok;
        begin
            rd(8'hDE);
            chk("early read", 0, rv);
            wait_done;
            chk("sig_ok", 1, sig_ok);
            chk("codes", 48'hA1B2C3D4, {vendor_code, device_code});
            chk("subsys", 48'h13572468, {subsys_vendor_code, subsys_code});
            chk("grant latency", 48'h113C, {min_grant_value, max_latency_value});
            chk("tbi", 1, ten_bit_if_enable);
            chk("cfg 0 1 3", 48'h054266, {boot_rom_size_cfg, led_map_cfg, wake_feature_cfg});
            chk("station", 48'h060504030201, station_addr_bytes);
            chk("lan wake", 1, lan_wake_enable);
            chk("card info", 48'h0080, card_info_pointer);
            chk("data starts", 48'h4000, {vpd_start, cis_start});
            chk("last word", 48'h18, last_addr);
            chk("opcode", 0, bad_op);
            chk("cfg4", 8'h53, fifo_wake_cfg);
            chk("checksum", 0, eeprom_checksum);
            rd(8'hDE);
            chk("pmc lo", 8'h02, rv);
            rd(8'h6C);
            chk("link tbi", 1, rv[7]);
            rd(8'h05);
            chk("station reg 5", 8'h06, rv);
        end
    endtask
    task t_gate;
        begin
            wr(8'h00, 8'hAA);
            rd(8'h00);
            chk("locked station", 8'h01, rv);
            wr(8'hE1, 8'hFF);
            chk("byte order", 8'h02, byte_order_cmd);
            wr(8'h50, 8'hC0);
            wr(8'h00, 8'hAA);
            rd(8'h00);
            chk("open station", 8'hAA, rv);
            wr(8'h51, 8'hFF);
            wr(8'h6C, 8'h00);
            rd(8'h51);
            chk("cfg0 read only", 8'h05, rv);
            rd(8'h6C);
            chk("link read only", 1, rv[7]);
        end
    endtask
    task t_bitbang;
        begin
            wr(8'h50, 8'hCE);
            chk("pins high", 3'b111, {ee_cs, ee_sk, ee_di});
            wr(8'h50, 8'hC8);
            chk("pins cs only", 3'b100, {ee_cs, ee_sk, ee_di});
            wr(8'h50, 8'h00);
        end
    endtask
    task t_pme;
        begin
            @(negedge mclk) pme_event = 1'b1;
            @(negedge mclk) {pme_event, pme_clear} = 2'b01;
            chk("pme set", 1, pme_status);
            @(negedge mclk) {pme_clear, d3cold_support_pme} = 2'b01;
            chk("pme cleared", 0, pme_status);
            @(negedge mclk) pme_event = 1'b1;
            @(negedge mclk) {pme_event, pme_clear, pci_reset} = 3'b011;
            @(negedge mclk) {pme_clear, pci_reset} = 2'b00;
            chk("pme sticky", 1, pme_status);
        end
    endtask
    task t_autoload_cmd;
        begin
            ee_u.mem[7] = 16'h0277;
            wr(8'h50, 8'h40);
            repeat (2) @(negedge mclk);
            wait_done;
            chk("reloaded station", 48'h060504030277, station_addr_bytes);
        end
    endtask
    task t_sig_bad;
        begin
            ee_u.mem[0] = 16'h1111;
            do_reset;
            wait_done;
            chk("sig bad", 0, sig_ok);
            chk("default codes", {`ECA_DEF_VENDOR, `ECA_DEF_DEVICE}, {vendor_code, device_code});
        end
    endtask
    task t_no_ee;
        reg seen;
        begin
            ee_u.mem[0] = 16'h5AA5;
            eeprom_present = 1'b0;
            do_reset;
            seen = 1'b0;
            repeat (200) @(negedge mclk) seen = seen | ee_cs;
            chk("no eeprom cs", 0, seen);
            chk("no eeprom done", 1, load_done);
            chk("no eeprom codes", {`ECA_DEF_VENDOR, `ECA_DEF_DEVICE}, {vendor_code, device_code});
            chk("no eeprom station", 0, station_addr_bytes);
        end
    endtask
    initial begin
        for (i = 0; i < 64; i = i + 1)
            ee_u.mem[i] = 16'h0000;
        ee_u.mem[0] = 16'h5AA5;
        ee_u.mem[1] = 16'hA1B2;
        ee_u.mem[2] = 16'hC3D4;
        ee_u.mem[3] = 16'h1357;
        ee_u.mem[4] = 16'h2468;
        ee_u.mem[5] = 16'h3C11;
        ee_u.mem[6] = 16'h6608;
        ee_u.mem[7] = 16'h0201;
        ee_u.mem[8] = 16'h0403;
        ee_u.mem[9] = 16'h0605;
        ee_u.mem[10] = 16'h4205;
        ee_u.mem[12] = 16'h5300;
        ee_u.mem[15] = 16'h0300;
        ee_u.mem[24] = 16'h0080;
        ee_u.mem[25] = 16'hBEEF;
        do_reset;
        t_load_ok;
        t_gate;
        t_bitbang;
        t_pme;
        t_autoload_cmd;
        t_sig_bad;
        t_no_ee;
        tally_and_finish;
    end
    // two full loads take about 11000 cycles
    initial begin
        #1500000;
        error_cnt = error_cnt + 1;
        tally_and_finish;
    end
endmodule // tb_eeprom_config_autoload
